// ---- common/dcs_pkg.sv ----
package dcs_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int SHUTDOWN_LEVEL_BIT = 0;
  localparam int SHUTDOWN_FLAG_BIT = 1;
  localparam int BATTERY_ABSENT_BIT = 2;
  localparam int BATTERY_FLAG_BIT = 3;
  localparam int SLOT_ONE_LSB = 4;
  localparam int SLOT_TWO_LSB = 6;
  localparam int SLOT_ONE_ENABLE_BIT = 0;
  localparam int SLOT_TWO_ENABLE_BIT = 4;
  localparam int SLOT_ONE_STATE_LSB = 2;
  localparam int SLOT_TWO_STATE_LSB = 6;

  typedef enum logic [1:0] {
    DCS_POWERED_DOWN = 2'h0,
    DCS_ISOLATED = 2'h1,
    DCS_POWERED_PD = 2'h2,
    DCS_ACTIVE = 2'h3
  } dcs_slot_status_t;

  // events and levels arriving from the detection logic
  typedef struct packed {
    logic shutdown_level;
    logic shutdown_event;
    logic battery_absent;
    logic battery_event;
  } dcs_events_t;
endpackage : dcs_pkg

// ---- design/dcs_slot_decode.sv ----
`timescale 1ns/1ps
module dcs_slot_decode (
  input wire logic [1:0] iface_state,
  input wire logic regulator_enable,
  output dcs_pkg::dcs_slot_status_t slot_status
);
  // regulator off forces powered-down; state 00 with power reads as 10
  wire logic [1:0] powered_status;
  assign powered_status = (iface_state == 2'h0) ? 2'h2 : iface_state;
  assign slot_status = dcs_pkg::dcs_slot_status_t'(regulator_enable ? powered_status
                                                                    : 2'h0);
endmodule : dcs_slot_decode

// ---- design/dcs_status_reg.sv ----
`timescale 1ns/1ps
module dcs_status_reg (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire dcs_pkg::dcs_events_t events,
  input wire logic [7:0] iface_control,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  logic shutdown_flag;
  logic battery_flag;
  dcs_pkg::dcs_slot_status_t slot_one_status;
  dcs_pkg::dcs_slot_status_t slot_two_status;

  wire logic status_sel;
  wire logic status_read;
  wire logic [7:0] status_value;
  wire logic next_shutdown_flag;
  wire logic next_battery_flag;

  assign status_sel = (reg_addr == dcs_pkg::STATUS_ADDR);
  assign status_read = clk_en && reg_rd && status_sel;

  // writes are decoded nowhere; reg_wr and reg_wdata only exist for bus symmetry
  // set wins over the read clear so a coincident event is not lost
  assign next_shutdown_flag = events.shutdown_event ||
                              (shutdown_flag && !status_read);
  assign next_battery_flag = events.battery_event ||
                             (battery_flag && !status_read);

  dcs_slot_decode u_slot_one (
    .iface_state(iface_control[dcs_pkg::SLOT_ONE_STATE_LSB +: 2]),
    .regulator_enable(iface_control[dcs_pkg::SLOT_ONE_ENABLE_BIT]),
    .slot_status(slot_one_status)
  );

  dcs_slot_decode u_slot_two (
    .iface_state(iface_control[dcs_pkg::SLOT_TWO_STATE_LSB +: 2]),
    .regulator_enable(iface_control[dcs_pkg::SLOT_TWO_ENABLE_BIT]),
    .slot_status(slot_two_status)
  );

  assign status_value = {slot_two_status, slot_one_status, battery_flag,
                         events.battery_absent, shutdown_flag,
                         events.shutdown_level};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shutdown_flag <= 1'b0;
      battery_flag <= 1'b0;
    end else if (clk_en) begin
      shutdown_flag <= next_shutdown_flag;
      battery_flag <= next_battery_flag;
    end
  end

  // read data is registered: it captures the value before the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= dcs_pkg::STATUS_RESET;
    end else if (status_read) begin
      reg_rdata <= status_value;
    end
  end

  a_flag_clear_read: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && status_read && !events.shutdown_event |=> !shutdown_flag)
    else $error("shutdown flag not cleared by read");
  a_flag_set_win: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && events.battery_event |=> battery_flag)
    else $error("battery flag missed event");
  a_flag_sd_set: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && events.shutdown_event |=> shutdown_flag)
    else $error("shutdown flag missed event");
  a_read_level_bit: assert property (@(posedge core_clk) disable iff (rst)
    status_read |=> reg_rdata[0] == $past(events.shutdown_level))
    else $error("shutdown level wrong");
  a_read_battery_bit: assert property (@(posedge core_clk) disable iff (rst)
    status_read |=> reg_rdata[2] == $past(events.battery_absent))
    else $error("battery status wrong");
  a_slot_off_down: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !iface_control[0] |=> reg_rdata[5:4] == 2'h0)
    else $error("slot one not powered down");
  a_slot_two_map: assert property (@(posedge core_clk) disable iff (rst)
    status_read && iface_control[4] && iface_control[7:6] == 2'h0
    |=> reg_rdata[7:6] == 2'h2)
    else $error("slot two powered status wrong");
  a_slot_one_pass: assert property (@(posedge core_clk) disable iff (rst)
    status_read && iface_control[0] && iface_control[3:2] != 2'h0
    |=> reg_rdata[5:4] == $past(iface_control[3:2]))
    else $error("slot one status wrong");
  a_write_no_effect: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && !reg_rd && clk_en |=> $stable(reg_rdata))
    else $error("write altered status");

  // a pending flag must be reported by the read and gone one cycle later
  sequence s_read_pending_sd;
    status_read && shutdown_flag && !events.shutdown_event;
  endsequence

  sequence s_reported_cleared_sd;
    reg_rdata[dcs_pkg::SHUTDOWN_FLAG_BIT] && !shutdown_flag;
  endsequence

  sequence s_read_pending_bat;
    status_read && battery_flag && !events.battery_event;
  endsequence

  sequence s_reported_cleared_bat;
    reg_rdata[dcs_pkg::BATTERY_FLAG_BIT] && !battery_flag;
  endsequence

  a_sd_read_report: assert property (@(posedge core_clk) disable iff (rst)
    s_read_pending_sd |=> s_reported_cleared_sd)
    else $error("shutdown flag not reported then cleared");

  a_bat_read_report: assert property (@(posedge core_clk) disable iff (rst)
    s_read_pending_bat |=> s_reported_cleared_bat)
    else $error("battery flag not reported then cleared");

  a_bat_clear_read: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !events.battery_event
    |=> !battery_flag)
    else $error("battery flag not cleared by read");

  // the read returns the flags as they stood before the clear
  a_read_flag_bits: assert property (@(posedge core_clk) disable iff (rst)
    status_read
    |=> reg_rdata[dcs_pkg::SHUTDOWN_FLAG_BIT] == $past(shutdown_flag) &&
        reg_rdata[dcs_pkg::BATTERY_FLAG_BIT] == $past(battery_flag))
    else $error("flag bits in read data wrong");

  // without an event or a read the flags keep their value
  a_sd_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !events.shutdown_event && !status_read
    |=> $stable(shutdown_flag))
    else $error("shutdown flag changed without cause");

  a_bat_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !events.battery_event && !status_read
    |=> $stable(battery_flag))
    else $error("battery flag changed without cause");

  // clock enable low freezes everything; an event in that cycle is lost
  a_freeze_state: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en
    |=> $stable({shutdown_flag, battery_flag}) && $stable(reg_rdata))
    else $error("state moved while frozen");

  a_freeze_event: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en && events.shutdown_event && !shutdown_flag
    |=> !shutdown_flag)
    else $error("shutdown event taken while frozen");

  // read data only moves on a taken read of the status address
  a_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
    !status_read
    |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_addr_refused: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && reg_rd && !status_sel
    |=> $stable(reg_rdata))
    else $error("other address changed read data");

  // reset clears both flags and the read data
  a_reset_clear: assert property (@(posedge core_clk)
    rst
    |=> reg_rdata == dcs_pkg::STATUS_RESET && !shutdown_flag && !battery_flag)
    else $error("reset did not clear status");

  // remaining slot mappings, one per table row kind
  a_slot_two_off: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !iface_control[dcs_pkg::SLOT_TWO_ENABLE_BIT]
    |=> reg_rdata[dcs_pkg::SLOT_TWO_LSB +: 2] == 2'h0)
    else $error("slot two not powered down");

  a_slot_one_map: assert property (@(posedge core_clk) disable iff (rst)
    status_read && iface_control[dcs_pkg::SLOT_ONE_ENABLE_BIT] &&
    iface_control[dcs_pkg::SLOT_ONE_STATE_LSB +: 2] == 2'h0
    |=> reg_rdata[dcs_pkg::SLOT_ONE_LSB +: 2] == 2'h2)
    else $error("slot one powered status wrong");

  a_slot_two_pass: assert property (@(posedge core_clk) disable iff (rst)
    status_read && iface_control[dcs_pkg::SLOT_TWO_ENABLE_BIT] &&
    iface_control[dcs_pkg::SLOT_TWO_STATE_LSB +: 2] != 2'h0
    |=> reg_rdata[dcs_pkg::SLOT_TWO_LSB +: 2] ==
        $past(iface_control[dcs_pkg::SLOT_TWO_STATE_LSB +: 2]))
    else $error("slot two status wrong");

  // slot fields sample the control contents at the read edge, not later
  a_slot_one_sample: assert property (@(posedge core_clk) disable iff (rst)
    status_read && !iface_control[dcs_pkg::SLOT_ONE_ENABLE_BIT]
    |=> reg_rdata[dcs_pkg::SLOT_ONE_LSB +: 2] == 2'h0)
    else $error("slot one sampled wrong enable");

  a_level_bits: assert property (@(posedge core_clk) disable iff (rst)
    status_read
    |=> reg_rdata[dcs_pkg::SHUTDOWN_LEVEL_BIT] == $past(events.shutdown_level) &&
        reg_rdata[dcs_pkg::BATTERY_ABSENT_BIT] == $past(events.battery_absent))
    else $error("level bits in read data wrong");

endmodule : dcs_status_reg

// ---- test/dcs_host_model.sv ----
`timescale 1ns/1ps
module dcs_host_model (
  input wire logic core_clk,
  input wire logic req,
  input wire logic [7:0] addr,
  output logic reg_rd,
  output logic [7:0] reg_addr
);
  // one strobe per request; an idle address is driven inverted so a stale value never looks valid
  always_ff @(posedge core_clk) begin
    reg_rd <= req;
    reg_addr <= req ? addr : ~addr;
  end
endmodule : dcs_host_model

// ---- test/tb_dual_card_status_register.sv ----
`timescale 1ns/1ps
module tb_dual_card_status_register;
  logic core_clk = 0, rst = 1, clk_en = 1, req = 0, reg_wr = 0, reg_rd;
  logic [7:0] addr = 8'h00, ctl = 8'h00, wdata = 8'h00, reg_rdata, reg_addr;
  dcs_pkg::dcs_events_t ev = '0;
  int err_count = 0, tests_run = 0;
  always #5 core_clk = ~core_clk;
  dcs_host_model host (.core_clk(core_clk), .req(req), .addr(addr), .reg_rd(reg_rd),
    .reg_addr(reg_addr));
  dcs_status_reg DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .events(ev),
    .iface_control(ctl), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(wdata), .reg_rdata(reg_rdata));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request, strobe edge, take edge, then sample once settled
  task rd(input logic [7:0] a, input logic [7:0] c);
    @(posedge core_clk);
    req <= 1'b1;
    addr <= a;
    ctl <= c;
    @(posedge core_clk);
    req <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : rd
  function automatic logic [1:0] slot_exp(input logic [1:0] s, input logic e);
    return e ? ((s == 2'b00) ? 2'b10 : s) : 2'b00;
  endfunction : slot_exp
  task t_slots;
    logic [1:0] s;
    for (int i = 0; i < 8; i++) begin
      s = i[1:0];
      // slot two gets the inverted setting so a swapped field shows up
      rd(8'h04, {~s, 1'b0, ~i[2], s, 1'b0, i[2]});
      chk(reg_rdata, {slot_exp(~s, ~i[2]), slot_exp(s, i[2]), 4'h0});
    end
    $display("slot test done");
  endtask : t_slots
  task t_flags;
    @(posedge core_clk);
    ev <= 4'hF;
    @(posedge core_clk);
    ev <= 4'hA;
    reg_wr <= 1'b1;
    wdata <= 8'hFF;
    rd(8'h08, 8'h00);
    chk(reg_rdata, 8'h30);
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h0F);
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h05);
    $display("flag test done");
  endtask : t_flags
  // event pulse on the very edge that takes the read: old flag read, flag kept
  task t_edge;
    @(posedge core_clk);
    req <= 1'b1;
    addr <= 8'h04;
    ctl <= 8'h00;
    @(posedge core_clk);
    req <= 1'b0;
    ev <= 4'hF;
    @(posedge core_clk);
    ev <= 4'hA;
    @(negedge core_clk);
    chk(reg_rdata, 8'h05);
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h0F);
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h05);
    $display("edge test done");
  endtask : t_edge
  // with clock enable low a read is refused and events are lost
  task t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    ev <= 4'h5;
    @(posedge core_clk);
    ev <= 4'h0;
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h05);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h00);
    $display("freeze test done");
  endtask : t_freeze
  task close_out;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h04, 8'h00);
    chk(reg_rdata, 8'h00);
    t_slots;
    t_flags;
    t_edge;
    t_freeze;
    close_out;
  end
endmodule : tb_dual_card_status_register
